// ---- logic/msvm_pkg.sv ----
// Operation
// (R1) Resolution code zero selects the native 256 microsteps per full step.
// (R2) Codes 1 to 8 select 128 down to fullstep, stepping the table by 2^code.
// (R3) Switch bit 19 set above the threshold forces chopper mode 1, decay 0.
// (R4) While that chopper override is active the off-time setting is doubled.
// (R5) Both fast-speed switches may be set together and act on one threshold.
// (R6) Switch bit 18 set above the threshold enters fullstep only at 45 deg.
// (R7) In fullstep the coil current is taken from the table entry at 45 deg.
// (R8) Sense bit 0 gives low sensitivity, 1 gives high sensitivity.
// (R9) Interpolation in 16 microstep step/dir mode spreads steps to 256.
// (R10) Software writes zero to bits 20..23 and ignores their read value.
package msvm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int THRESH_W = 20;
	localparam int POS_W = 10;
	localparam int CNT_W = 16;

	localparam logic [7:0] ADDR_CONF   = 8'h00;
	localparam logic [7:0] ADDR_THRESH = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	localparam int OFF_TIME_SETTING_LSB   = 0;
	localparam int OFF_TIME_SETTING_W     = 4;
	localparam int FD_BIT     = 12;
	localparam int CHM_BIT    = 14;
	localparam int SENSE_BIT  = 17;
	localparam int FS_SW_BIT  = 18;
	localparam int CHM_SW_BIT = 19;
	localparam int RES_LSB    = 24;
	localparam int RES_W      = 4;
	localparam int INTPOL_BIT = 28;

	// Reserved 20..23 and unused bits are not stored and read zero
	localparam logic [31:0] CONF_MASK   = 32'h1F0E_500F;
	localparam logic [31:0] CONF_RESET  = 32'h0000_0000;
	localparam logic [19:0] THRESH_RESET = 20'h0_0000;

	localparam int ST_FULL_BIT   = 0;
	localparam int ST_CHM_BIT    = 1;
	localparam int ST_FD_BIT     = 2;
	localparam int ST_HV_BIT     = 3;
	localparam int ST_WAIT_BIT   = 4;
	localparam int ST_OFF_TIME_SETTING_LSB   = 8;
	localparam int ST_POS_LSB    = 16;

	localparam logic [3:0] RES_NATIVE  = 4'h0;
	localparam logic [3:0] RES_FULL    = 4'h8;
	localparam logic [3:0] RES_SIXTEEN = 4'h4;

	localparam logic [7:0] POS_45DEG     = 8'h80;
	localparam logic [8:0] FULL_STEP_INC = 9'h100;
	localparam logic [4:0] INTERP_STEPS  = 5'h10;
	localparam int INTERP_SHIFT = 4;

	typedef enum logic [2:0] {
		MSVM_MICRO = 3'b001,
		MSVM_WAIT  = 3'b010,
		MSVM_FULL  = 3'b100
	} msvm_state_t;

	// Table advance per sequencer step; codes above 8 clamp to fullstep
	function automatic logic [8:0] msvm_step_width(input logic [3:0] code);
		logic [8:0] w;
		w = 9'h001;
		if (code >= RES_FULL) begin
			w = FULL_STEP_INC;
		end else begin
			w = 9'h001 << code;
		end
		return w;
	endfunction
endpackage

// ---- logic/msvm_if.sv ----
`timescale 1ns/1ps
interface msvm_if;
	logic       step;
	logic       step_dir;
	logic [3:0] code;
	logic       intpol_en;
	logic       inc_valid;
	logic [8:0] inc_amt;
	logic       inc_dir;

	modport ctl (output step, step_dir, code, intpol_en,
		input inc_valid, inc_amt, inc_dir);
	modport seq (input step, step_dir, code, intpol_en,
		output inc_valid, inc_amt, inc_dir);
endinterface

// ---- logic/msvm_stepper.sv ----
`timescale 1ns/1ps
module msvm_stepper (
	input  wire logic i_core_clk,
	input  wire logic i_srst,
	input  wire logic i_ce,
	msvm_if.seq       bus
);
	typedef struct packed {
		logic [15:0] period_cnt;
		logic [15:0] pace;
		logic [15:0] tick;
		logic [4:0]  rem;
		logic        dir;
		logic        inc_valid;
		logic [8:0]  inc_amt;
		logic        inc_dir;
	} msvm_seq_t;

	msvm_seq_t s_reg;
	msvm_seq_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.inc_valid = 1'b0;
		if (s_reg.period_cnt != 16'hFFFF) begin
			s_next.period_cnt = s_reg.period_cnt + 16'h0001;
		end
		if (bus.step) begin
			if (bus.intpol_en) begin
				// Leftover substeps are flushed so no position is lost
				s_next.inc_valid = (s_reg.rem != 5'h00); // [R9]
				s_next.inc_amt = {4'h0, s_reg.rem};
				s_next.inc_dir = s_reg.dir;
				s_next.rem = msvm_pkg::INTERP_STEPS; // [R9]
				s_next.dir = bus.step_dir;
				s_next.pace = s_reg.period_cnt >> msvm_pkg::INTERP_SHIFT;
				s_next.period_cnt = 16'h0000;
				s_next.tick = 16'h0000;
			end else begin
				s_next.inc_valid = 1'b1;
				s_next.inc_amt = msvm_pkg::msvm_step_width(bus.code); // [R1] [R2]
				s_next.inc_dir = bus.step_dir;
				s_next.rem = 5'h00;
				s_next.period_cnt = 16'h0000;
			end
		end else if (s_reg.rem != 5'h00) begin
			if (s_reg.tick >= s_reg.pace) begin
				s_next.inc_valid = 1'b1; // [R9]
				s_next.inc_amt = 9'h001;
				s_next.inc_dir = s_reg.dir;
				s_next.rem = s_reg.rem - 5'h01;
				s_next.tick = 16'h0000;
			end else begin
				s_next.tick = s_reg.tick + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_reg <= '0;
		end else if (i_ce) begin
			s_reg <= s_next;
		end
	end

	assign bus.inc_valid = s_reg.inc_valid;
	assign bus.inc_amt   = s_reg.inc_amt;
	assign bus.inc_dir   = s_reg.inc_dir;
endmodule

// ---- logic/msvm_top.sv ----
`timescale 1ns/1ps
module msvm_top #(
	parameter int THRESH_W = msvm_pkg::THRESH_W
) (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_srst,
	input  wire logic                  i_ce,
	input  wire logic [7:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	input  wire logic [THRESH_W-1:0]   i_velocity,
	input  wire logic                  i_step,
	input  wire logic                  i_step_dir,
	input  wire logic                  i_stepdir_mode,
	output logic      [31:0]           o_rdata,
	output logic      [9:0]            o_table_addr,
	output logic                       o_fullstep,
	output logic                       o_chopper_mode,
	output logic                       o_fast_decay_select,
	output logic      [4:0]            o_off_time_setting,
	output logic                       o_sense_high
);
	typedef struct packed {
		logic [31:0]          conf;
		logic [THRESH_W-1:0]  thresh;
		logic [31:0]          rdata;
		msvm_pkg::msvm_state_t st;
		logic [9:0]           pos;
		logic [9:0]           table_addr;
		logic                 full;
		logic                 chm;
		logic                 fd;
		logic [4:0]           off_time_setting;
		logic                 sense;
		logic                 hv;
	} msvm_top_t;

	msvm_top_t s_reg;
	msvm_top_t s_next;
	msvm_if    seq_bus ();

	logic       hv_now;
	logic       fs_req;
	logic       chm_ovr;
	logic [3:0] code;
	logic [3:0] off_time_setting_raw;
	logic [31:0] status;

	// =========================================================
	// Field decode
	// =========================================================
	assign code = s_reg.conf[msvm_pkg::RES_LSB +: msvm_pkg::RES_W];
	assign off_time_setting_raw = s_reg.conf[msvm_pkg::OFF_TIME_SETTING_LSB +: msvm_pkg::OFF_TIME_SETTING_W];
	// Strictly above: equal velocity is not yet exceeded
	assign hv_now = (i_velocity > s_reg.thresh);
	// Both switches read one comparison, so they may act together
	assign fs_req = s_reg.conf[msvm_pkg::FS_SW_BIT] & hv_now; // [R5] [R6]
	assign chm_ovr = s_reg.conf[msvm_pkg::CHM_SW_BIT] & hv_now; // [R5] [R3]

	assign seq_bus.step = i_step & (s_reg.st != msvm_pkg::MSVM_FULL);
	assign seq_bus.step_dir = i_step_dir;
	assign seq_bus.code = code;
	assign seq_bus.intpol_en = s_reg.conf[msvm_pkg::INTPOL_BIT]
		& (code == msvm_pkg::RES_SIXTEEN) & i_stepdir_mode; // [R9]

	msvm_stepper u_stepper (
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.i_ce       (i_ce),
		.bus        (seq_bus)
	);

	always_comb begin
		status = 32'h0000_0000;
		status[msvm_pkg::ST_FULL_BIT] = s_reg.full;
		status[msvm_pkg::ST_CHM_BIT] = s_reg.chm;
		status[msvm_pkg::ST_FD_BIT] = s_reg.fd;
		status[msvm_pkg::ST_HV_BIT] = s_reg.hv;
		status[msvm_pkg::ST_WAIT_BIT] = (s_reg.st == msvm_pkg::MSVM_WAIT);
		status[msvm_pkg::ST_OFF_TIME_SETTING_LSB +: 5] = s_reg.off_time_setting;
		status[msvm_pkg::ST_POS_LSB +: 10] = s_reg.pos;
	end

	// =========================================================
	// Next state
	// =========================================================
	always_comb begin
		s_next = s_reg;
		s_next.hv = hv_now;
		s_next.rdata = 32'h0000_0000;

		if (i_wr) begin
			unique case (i_addr)
				msvm_pkg::ADDR_CONF: begin
					// Reserved bits are dropped whatever software writes
					s_next.conf = i_wdata & msvm_pkg::CONF_MASK; // [R10]
				end
				msvm_pkg::ADDR_THRESH: begin
					s_next.thresh = i_wdata[THRESH_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				msvm_pkg::ADDR_CONF: begin
					s_next.rdata = s_reg.conf;
				end
				msvm_pkg::ADDR_THRESH: begin
					s_next.rdata = 32'(s_reg.thresh);
				end
				msvm_pkg::ADDR_STATUS: begin
					s_next.rdata = status;
				end
				default: begin
					s_next.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Table position: sub-sequencer steps, or whole steps in fullstep
		if (s_reg.st == msvm_pkg::MSVM_FULL) begin
			if (i_step) begin
				s_next.pos = i_step_dir
					? s_reg.pos - 10'(msvm_pkg::FULL_STEP_INC)
					: s_reg.pos + 10'(msvm_pkg::FULL_STEP_INC);
			end
		end else if (seq_bus.inc_valid) begin
			s_next.pos = seq_bus.inc_dir
				? s_reg.pos - 10'(seq_bus.inc_amt)
				: s_reg.pos + 10'(seq_bus.inc_amt); // [R2]
		end

		unique case (s_reg.st)
			msvm_pkg::MSVM_MICRO: begin
				if (fs_req) begin
					if (s_reg.pos[7:0] == msvm_pkg::POS_45DEG) begin
						s_next.st = msvm_pkg::MSVM_FULL; // [R6]
					end else begin
						s_next.st = msvm_pkg::MSVM_WAIT; // [R6]
					end
				end
			end
			msvm_pkg::MSVM_WAIT: begin
				// Keep microstepping until the position lands exactly on the 45 deg point
				if (!fs_req) begin
					s_next.st = msvm_pkg::MSVM_MICRO;
				end else if (s_reg.pos[7:0] == msvm_pkg::POS_45DEG) begin
					s_next.st = msvm_pkg::MSVM_FULL; // [R6]
				end
			end
			msvm_pkg::MSVM_FULL: begin
				if (!fs_req) begin
					s_next.st = msvm_pkg::MSVM_MICRO;
				end
			end
		endcase

		s_next.full = (s_next.st == msvm_pkg::MSVM_FULL);
		if (s_next.full) begin
			s_next.table_addr = {s_next.pos[9:8], msvm_pkg::POS_45DEG}; // [R7]
		end else begin
			s_next.table_addr = s_next.pos;
		end

		if (chm_ovr) begin
			s_next.chm = 1'b1; // [R3]
			s_next.fd = 1'b0; // [R3]
			// Doubling keeps the chopper frequency from doubling
			s_next.off_time_setting = {off_time_setting_raw, 1'b0}; // [R4]
		end else begin
			s_next.chm = s_reg.conf[msvm_pkg::CHM_BIT];
			s_next.fd = s_reg.conf[msvm_pkg::FD_BIT];
			s_next.off_time_setting = {1'b0, off_time_setting_raw};
		end
		s_next.sense = s_reg.conf[msvm_pkg::SENSE_BIT]; // [R8]
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_reg <= '0;
			s_reg.conf <= msvm_pkg::CONF_RESET;
			s_reg.thresh <= THRESH_W'(msvm_pkg::THRESH_RESET);
			s_reg.st <= msvm_pkg::MSVM_MICRO;
		end else if (i_ce) begin
			s_reg <= s_next;
		end
	end

	assign o_rdata = s_reg.rdata;
	assign o_table_addr = s_reg.table_addr;
	assign o_fullstep = s_reg.full;
	assign o_chopper_mode = s_reg.chm;
	assign o_fast_decay_select = s_reg.fd;
	assign o_off_time_setting = s_reg.off_time_setting;
	assign o_sense_high = s_reg.sense;
endmodule

// ---- tb/msvm_checker.sv ----
`timescale 1ns/1ps
module msvm_checker #(
	parameter int THRESH_W = 20
) (
	input wire logic                i_core_clk,
	input wire logic                i_srst,
	input wire logic [7:0]          i_addr,
	input wire logic [31:0]         i_wdata,
	input wire logic                i_wr,
	input wire logic                i_rd,
	input wire logic [THRESH_W-1:0] i_velocity,
	input wire logic [31:0]         o_rdata,
	input wire logic [9:0]          o_table_addr,
	input wire logic                o_fullstep,
	input wire logic                o_chopper_mode,
	input wire logic                o_fast_decay_select,
	input wire logic [4:0]          o_off_time_setting,
	input wire logic                o_sense_high
);
	// Shadow copies; the bench never writes while the enable is low
	logic [31:0]         conf_reg;
	logic [THRESH_W-1:0] thr_reg;
	wire logic           hv     = i_velocity > thr_reg;
	wire logic           chm_ov = hv && conf_reg[19];
	wire logic           fs_ok  = hv && conf_reg[18];
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			conf_reg <= 32'h0;
			thr_reg  <= '0;
		end else if (i_wr && i_addr == msvm_pkg::ADDR_CONF) begin
			conf_reg <= i_wdata & msvm_pkg::CONF_MASK;
		end else if (i_wr && i_addr == msvm_pkg::ADDR_THRESH) begin
			thr_reg <= i_wdata[THRESH_W-1:0];
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	a_chm_forced: assert property (chm_ov |=> o_chopper_mode
		&& !o_fast_decay_select) else $error("override not applied");
	a_off_time_setting_double: assert property (chm_ov |=>
		o_off_time_setting == {$past(conf_reg[3:0]), 1'b0})
		else $error("off time not doubled");
	a_mode_plain: assert property (!chm_ov |=>
		o_chopper_mode == $past(conf_reg[14])
		&& o_fast_decay_select == $past(conf_reg[12])
		&& o_off_time_setting == {1'b0, $past(conf_reg[3:0])})
		else $error("plain chopper fields wrong");
	a_sense_sel: assert property (o_sense_high == $past(conf_reg[17]))
		else $error("sense select wrong");
	a_fs_exit: assert property ((!fs_ok) [*2] |=> !o_fullstep)
		else $error("fullstep without cause");
	a_fs_entry: assert property ($rose(o_fullstep) |->
		$past(fs_ok) || $past(fs_ok, 2)) else $error("fullstep entry");
	a_fs_angle: assert property (o_fullstep |->
		o_table_addr[7:0] == msvm_pkg::POS_45DEG)
		else $error("fullstep off 45 degrees");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside slot");
	a_conf_read: assert property ($past(i_rd && i_addr == 8'h00) |->
		o_rdata == $past(conf_reg)) else $error("conf readback");
endmodule
bind msvm_top msvm_checker #(.THRESH_W(THRESH_W)) i_msvm_checker (
	.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_velocity(i_velocity),
	.o_rdata(o_rdata), .o_table_addr(o_table_addr), .o_fullstep(o_fullstep),
	.o_chopper_mode(o_chopper_mode),
	.o_fast_decay_select(o_fast_decay_select),
	.o_off_time_setting(o_off_time_setting), .o_sense_high(o_sense_high));

// ---- tb/msvm_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	errors++; $display("Error %s expected %0h seen %0h", n, e, s); end end
module msvm_bench;
	logic        i_core_clk, i_srst, i_ce, i_wr, i_rd, i_step;
	logic        i_step_dir, i_stepdir_mode;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, d;
	logic [19:0] i_velocity;
	logic [9:0]  o_table_addr, p, q;
	logic [4:0]  o_off_time_setting;
	logic        o_fullstep, o_chopper_mode, o_fast_decay_select, o_sense_high;
	int          errors, comparisons, n;
	msvm_top i_msvm_top (.i_core_clk(i_core_clk), .i_srst(i_srst),
		.i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .i_velocity(i_velocity), .i_step(i_step),
		.i_step_dir(i_step_dir), .i_stepdir_mode(i_stepdir_mode),
		.o_rdata(o_rdata), .o_table_addr(o_table_addr),
		.o_fullstep(o_fullstep), .o_chopper_mode(o_chopper_mode),
		.o_fast_decay_select(o_fast_decay_select),
		.o_off_time_setting(o_off_time_setting), .o_sense_high(o_sense_high));
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	// Settle past the edge so checks never race the design's updates
	task automatic cyc(input int k);
		repeat (k) @(posedge i_core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_core_clk);
		i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_core_clk);
		i_addr <= a; i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task automatic stp(input logic dir);
		@(posedge i_core_clk);
		i_step <= 1'b1; i_step_dir <= dir;
		@(posedge i_core_clk);
		i_step <= 1'b0;
	endtask
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_core_clk);
		errors++;
		end_sim();
	end
	initial begin
		{i_srst, i_ce} = 2'b11; {i_wr, i_rd, i_step, i_step_dir} = 4'h0;
		i_stepdir_mode = 1'b0; i_addr = 8'h00; i_wdata = 32'h0;
		i_velocity = 20'h0;
		repeat (4) @(posedge i_core_clk);
		i_srst <= 1'b0;
		rd(msvm_pkg::ADDR_CONF, d); `CHK("conf reset", 32'h0, d)
		// Reserved bits 20..23 are written as zero
		wr(msvm_pkg::ADDR_CONF, 32'hFF0F_FFFF);
		rd(msvm_pkg::ADDR_CONF, d);
		`CHK("conf mask", msvm_pkg::CONF_MASK, d)
		rd(8'h0C, d); `CHK("unmapped", 32'h0, d)
		$display("test registers done");
		for (int c = 0; c <= 8; c++) begin
			wr(msvm_pkg::ADDR_CONF, c << msvm_pkg::RES_LSB); cyc(2);
			p = o_table_addr; stp(c[0]); cyc(4);
			q = c[0] ? p - (10'h1 << c) : p + (10'h1 << c);
			`CHK("step", q, o_table_addr)
		end
		$display("test resolution done");
		wr(msvm_pkg::ADDR_THRESH, 32'h64);
		rd(msvm_pkg::ADDR_THRESH, d); `CHK("thresh", 32'h64, d)
		wr(msvm_pkg::ADDR_CONF, 32'h000A_1005);
		for (int k = 0; k < 2; k++) begin
			@(posedge i_core_clk) i_velocity <= 20'h64 + k;
			cyc(3);
			`CHK("chm", k[0], o_chopper_mode)
			`CHK("fd", !k[0], o_fast_decay_select)
			`CHK("off_time_setting", k ? 5'hA : 5'h5, o_off_time_setting)
			`CHK("sense high", 1'b1, o_sense_high)
		end
		$display("test override done");
		wr(msvm_pkg::ADDR_CONF, 32'h000C_0005); cyc(2);
		`CHK("sense low", 1'b0, o_sense_high)
		n = 0;
		while (o_table_addr[7:0] !== 8'h80 && n < 300) begin
			`CHK("wait angle", 1'b0, o_fullstep)
			stp(1'b0); cyc(4); n++;
		end
		cyc(2); `CHK("full", 1'b1, o_fullstep)
		`CHK("full off_time_setting", 5'hA, o_off_time_setting)
		// Full, override on, fast decay off, fast, off_time_setting 0xA, pos 0x180
		rd(msvm_pkg::ADDR_STATUS, d);
		`CHK("status full", 32'h0180_0A0B, d)
		p = o_table_addr; stp(1'b0); cyc(3);
		`CHK("full step", p + 10'h100, o_table_addr)
		@(posedge i_core_clk) i_velocity <= 20'h64;
		cyc(4); `CHK("full exit", 1'b0, o_fullstep)
		$display("test fullstep done");
		@(posedge i_core_clk) i_stepdir_mode <= 1'b1;
		wr(msvm_pkg::ADDR_CONF, 32'h1400_0000);
		stp(1'b0); cyc(300); p = o_table_addr; stp(1'b0); cyc(6);
		`CHK("interp part", 1'b1, (o_table_addr - p) < 10'h10)
		cyc(320); `CHK("interp all", p + 10'h10, o_table_addr)
		$display("test interpolation done");
		// A step seen while the enable is low must leave no trace
		@(posedge i_core_clk) i_ce <= 1'b0;
		p = o_table_addr;
		stp(1'b0);
		cyc(3);
		@(posedge i_core_clk) i_ce <= 1'b1;
		cyc(40);
		`CHK("ce freeze", p, o_table_addr)
		$display("test clock enable done");
		end_sim();
	end
endmodule
